// ==== rtl/aoa_output_map.vh ====
// constants for the converter output alignment and over-range stage
// assumes inclusion by aoa_output_stage.v and aoa_delay_line.v only
`ifndef AOA_OUTPUT_MAP_VH
`define AOA_OUTPUT_MAP_VH

// =============================================================
// register offsets and layout
`define AOA_ADDR_I_RANGE      4'h3
`define AOA_ADDR_Q_RANGE      4'hB
`define AOA_RANGE_RESET       16'h4000
`define AOA_RANGE_MSB         14
`define AOA_RANGE_READ_MASK   16'h7FFF

// =============================================================
// full-scale range codes used outside extended control mode
`define AOA_RANGE_MID         15'h4000
`define AOA_RANGE_HIGH        15'h7FFF

// =============================================================
// conversion
`define AOA_CODE_WIDTH        10
`define AOA_ANALOG_WIDTH      12
`define AOA_CODE_MID          13'h0200
`define AOA_CODE_MAX          13'h03FF
`define AOA_CODE_ALL_ONES     10'h3FF
`define AOA_CODE_ALL_ZEROS    10'h000

// =============================================================
// timing
`define AOA_LAT_PRIMARY       34
`define AOA_LAT_DELAYED       35
`define AOA_OUTPUT_DELAY_NS   20
`define AOA_CLOCK_PERIOD_NS   10

`endif

// ==== rtl/aoa_delay_line.v ====
// sample pipeline: shift register with two fixed taps
// assumes shiftEn is a one-cycle strobe in the clock domain
`timescale 1ns/1ps
`include "aoa_output_map.vh"

module aoa_delay_line #(
    parameter WIDTH = 22,
    parameter TAP_A = `AOA_LAT_PRIMARY,
    parameter TAP_B = `AOA_LAT_DELAYED
) (
    input  wire             clock,
    input  wire             srst,
    input  wire             shiftEn,
    input  wire [WIDTH-1:0] dataIn,
    output wire [WIDTH-1:0] tapA,
    output wire [WIDTH-1:0] tapB
);

    // entry j holds the sample pushed j strobes before the newest
    reg [WIDTH-1:0] stage_reg [0:TAP_B];

    // =============================================================
    // shift chain
    always @(posedge clock) begin
        if (srst) begin
            stage_reg[0] <= {WIDTH{1'b0}};
        end else if (shiftEn) begin
            stage_reg[0] <= dataIn;
        end
    end

    genvar gi;
    generate
        for (gi = 1; gi <= TAP_B; gi = gi + 1) begin : gStage
            always @(posedge clock) begin
                if (srst) begin
                    stage_reg[gi] <= {WIDTH{1'b0}};
                end else if (shiftEn) begin
                    stage_reg[gi] <= stage_reg[gi-1];
                end
            end
        end
    endgenerate

    assign tapA = stage_reg[TAP_A];
    assign tapB = stage_reg[TAP_B];

endmodule

// ==== rtl/aoa_output_stage.v ====
// converter digital output stage: sampling edges, pipeline alignment,
// clipping, over-range flags, bus enables and full-scale range select
// assumes sampleClk, mode pins and analog words come from outside the
// clock domain; the register port is driven from this clock domain
`timescale 1ns/1ps
`include "aoa_output_map.vh"

module aoa_output_stage #(
    parameter CODE_WIDTH   = `AOA_CODE_WIDTH,
    parameter ANALOG_WIDTH = `AOA_ANALOG_WIDTH
) (
    input  wire                    clock,
    input  wire                    srst,
    input  wire                    sampleClk,
    input  wire [ANALOG_WIDTH-1:0] iAnalog,
    input  wire [ANALOG_WIDTH-1:0] qAnalog,
    input  wire                    demuxMode,
    input  wire                    bothEdgeMode,
    input  wire                    extended_control_mode,
    input  wire                    full_scale_select_pin,
    input  wire                    regWriteEn,
    input  wire [3:0]              regAddr,
    input  wire [15:0]             regWriteData,
    output reg  [15:0]             regReadData,
    output reg  [CODE_WIDTH-1:0]   primary_i_bus,
    output reg                     primaryIBusOe,
    output reg  [CODE_WIDTH-1:0]   primary_q_bus,
    output reg                     primaryQBusOe,
    output reg  [CODE_WIDTH-1:0]   delayed_i_bus,
    output reg                     delayedIBusOe,
    output reg  [CODE_WIDTH-1:0]   delayed_q_bus,
    output reg                     delayedQBusOe,
    output reg                     i_over_range_flag,
    output reg                     q_over_range_flag,
    output reg  [14:0]             iRangeCode,
    output reg  [14:0]             qRangeCode
);

    localparam WORD_WIDTH  = CODE_WIDTH + 1;
    localparam RISE_WIDTH  = 2 * WORD_WIDTH;
    localparam DELAY_CYCLES =
        (`AOA_OUTPUT_DELAY_NS + `AOA_CLOCK_PERIOD_NS - 1) / `AOA_CLOCK_PERIOD_NS;
    localparam DELAY_LEN   = (DELAY_CYCLES < 1) ? 1 : DELAY_CYCLES;

    // =============================================================
    // input synchronisers
    reg                    sampleClkMeta_reg;
    reg                    sampleClkSync_reg;
    reg                    sampleClkLast_reg;
    reg [3:0]              modeMeta_reg;
    reg [3:0]              modeSync_reg;
    reg [ANALOG_WIDTH-1:0] iMeta_reg;
    reg [ANALOG_WIDTH-1:0] iSync_reg;
    reg [ANALOG_WIDTH-1:0] qMeta_reg;
    reg [ANALOG_WIDTH-1:0] qSync_reg;

    always @(posedge clock) begin
        if (srst) begin
            sampleClkMeta_reg <= 1'b0;
            sampleClkSync_reg <= 1'b0;
            sampleClkLast_reg <= 1'b0;
            modeMeta_reg      <= 4'h0;
            modeSync_reg      <= 4'h0;
            iMeta_reg         <= {ANALOG_WIDTH{1'b0}};
            iSync_reg         <= {ANALOG_WIDTH{1'b0}};
            qMeta_reg         <= {ANALOG_WIDTH{1'b0}};
            qSync_reg         <= {ANALOG_WIDTH{1'b0}};
        end else begin
            sampleClkMeta_reg <= sampleClk;
            sampleClkSync_reg <= sampleClkMeta_reg;
            sampleClkLast_reg <= sampleClkSync_reg;
            modeMeta_reg      <= {full_scale_select_pin, extended_control_mode,
                                  bothEdgeMode, demuxMode};
            modeSync_reg      <= modeMeta_reg;
            iMeta_reg         <= iAnalog;
            iSync_reg         <= iMeta_reg;
            qMeta_reg         <= qAnalog;
            qSync_reg         <= qMeta_reg;
        end
    end

    wire demuxOn    = modeSync_reg[0];
    wire bothEdgeOn = modeSync_reg[1];
    wire ecmOn      = modeSync_reg[2];
    wire fsrPinHigh = modeSync_reg[3];

    // =============================================================
    // sampling edges
    // free running: every rising edge converts, falling edges only in both-edge mode; nothing arms it
    wire riseEdge = sampleClkSync_reg & ~sampleClkLast_reg;
    wire fallEdge = ~sampleClkSync_reg & sampleClkLast_reg & bothEdgeOn;

    // =============================================================
    // clipping: input is a signed offset from mid code
    function [WORD_WIDTH-1:0] clipWord;
        input [ANALOG_WIDTH-1:0] analog;
        reg signed [12:0] sum;
        begin
            sum = $signed({{(13-ANALOG_WIDTH){analog[ANALOG_WIDTH-1]}}, analog})
                  + $signed(`AOA_CODE_MID);
            if (sum > $signed(`AOA_CODE_MAX)) begin
                clipWord = {1'b1, `AOA_CODE_ALL_ONES};
            end else if (sum < 0) begin
                clipWord = {1'b1, `AOA_CODE_ALL_ZEROS};
            end else begin
                clipWord = {1'b0, sum[CODE_WIDTH-1:0]};
            end
        end
    endfunction

    wire [WORD_WIDTH-1:0] iWord = clipWord(iSync_reg);
    wire [WORD_WIDTH-1:0] qWord = clipWord(qSync_reg);

    // both-edge mode carries the Q channel in the I slot
    wire [RISE_WIDTH-1:0] riseEntry = {(bothEdgeOn ? qWord : iWord), qWord};

    // =============================================================
    // pipelines: one for rising samples, one for falling samples
    wire [RISE_WIDTH-1:0] riseTapPrimary;
    wire [RISE_WIDTH-1:0] riseTapDelayed;
    wire [WORD_WIDTH-1:0] fallTapPrimary;
    wire [WORD_WIDTH-1:0] fallTapDelayed;

    aoa_delay_line #(
        .WIDTH (RISE_WIDTH),
        .TAP_A (`AOA_LAT_PRIMARY),
        .TAP_B (`AOA_LAT_DELAYED)
    ) uRiseLine (
        .clock   (clock),
        .srst    (srst),
        .shiftEn (riseEdge),
        .dataIn  (riseEntry),
        .tapA    (riseTapPrimary),
        .tapB    (riseTapDelayed)
    );

    // a falling entry j steps back is 34.5 cycles old at the next rise for j = 34
    aoa_delay_line #(
        .WIDTH (WORD_WIDTH),
        .TAP_A (`AOA_LAT_PRIMARY),
        .TAP_B (`AOA_LAT_DELAYED)
    ) uFallLine (
        .clock   (clock),
        .srst    (srst),
        .shiftEn (fallEdge),
        .dataIn  (qWord),
        .tapA    (fallTapPrimary),
        .tapB    (fallTapDelayed)
    );

    // =============================================================
    // output delay after each rising edge
    // taps settle one cycle after the edge, so the delay covers that too
    reg [DELAY_LEN-1:0] loadPipe_reg;
    reg [DELAY_LEN-1:0] loadPipe_next;
    reg                 demuxPhase_reg;

    // edge enters at bit 0 of the chain, so a one-stage delay
    // needs no branch with an empty part-select
    wire [DELAY_LEN:0] loadChain = {loadPipe_reg, riseEdge};

    always @* begin
        loadPipe_next = loadChain[DELAY_LEN-1:0];
    end

    always @(posedge clock) begin
        if (srst) begin
            loadPipe_reg   <= {DELAY_LEN{1'b0}};
            demuxPhase_reg <= 1'b0;
        end else begin
            loadPipe_reg   <= loadPipe_next;
            if (riseEdge) begin
                demuxPhase_reg <= demuxOn ? ~demuxPhase_reg : 1'b0;
            end
        end
    end

    // demux presents a pair every second rise; delayed word is the older one
    wire loadNow = loadPipe_reg[DELAY_LEN-1] & (~demuxOn | demuxPhase_reg);

    // =============================================================
    // bus word selection
    wire [WORD_WIDTH-1:0] selPrimaryI = riseTapPrimary[RISE_WIDTH-1:WORD_WIDTH];
    wire [WORD_WIDTH-1:0] selPrimaryQ = bothEdgeOn ? fallTapPrimary
                                                   : riseTapPrimary[WORD_WIDTH-1:0];
    wire [WORD_WIDTH-1:0] selDelayedI = riseTapDelayed[RISE_WIDTH-1:WORD_WIDTH];
    wire [WORD_WIDTH-1:0] selDelayedQ = bothEdgeOn ? fallTapDelayed
                                                   : riseTapDelayed[WORD_WIDTH-1:0];

    always @(posedge clock) begin
        if (srst) begin
            primary_i_bus     <= {CODE_WIDTH{1'b0}};
            primary_q_bus     <= {CODE_WIDTH{1'b0}};
            delayed_i_bus     <= {CODE_WIDTH{1'b0}};
            delayed_q_bus     <= {CODE_WIDTH{1'b0}};
            i_over_range_flag <= 1'b0;
            q_over_range_flag <= 1'b0;
        end else if (loadNow) begin
            primary_i_bus <= selPrimaryI[CODE_WIDTH-1:0];
            primary_q_bus <= selPrimaryQ[CODE_WIDTH-1:0];
            if (demuxOn) begin
                delayed_i_bus <= selDelayedI[CODE_WIDTH-1:0];
                delayed_q_bus <= selDelayedQ[CODE_WIDTH-1:0];
            end
            // flag follows the words on show, so it lasts while clipping does
            i_over_range_flag <= selPrimaryI[CODE_WIDTH] |
                                 (demuxOn & selDelayedI[CODE_WIDTH]);
            q_over_range_flag <= selPrimaryQ[CODE_WIDTH] |
                                 (demuxOn & selDelayedQ[CODE_WIDTH]);
        end
    end

    // =============================================================
    // bus enables
    always @(posedge clock) begin
        if (srst) begin
            primaryIBusOe <= 1'b0;
            primaryQBusOe <= 1'b0;
            delayedIBusOe <= 1'b0;
            delayedQBusOe <= 1'b0;
        end else begin
            primaryIBusOe <= 1'b1;
            primaryQBusOe <= 1'b1;
            delayedIBusOe <= demuxOn;
            delayedQBusOe <= demuxOn;
        end
    end

    // =============================================================
    // full-scale range registers
    reg [15:0] iRange_reg;
    reg [15:0] qRange_reg;

    always @(posedge clock) begin
        if (srst) begin
            iRange_reg <= `AOA_RANGE_RESET;
            qRange_reg <= `AOA_RANGE_RESET;
        end else if (regWriteEn) begin
            if (regAddr == `AOA_ADDR_I_RANGE) begin
                iRange_reg <= regWriteData & `AOA_RANGE_READ_MASK;
            end else if (regAddr == `AOA_ADDR_Q_RANGE) begin
                qRange_reg <= regWriteData & `AOA_RANGE_READ_MASK;
            end
        end
    end

    always @(posedge clock) begin
        if (srst) begin
            regReadData <= 16'h0000;
        end else if (regAddr == `AOA_ADDR_I_RANGE) begin
            regReadData <= iRange_reg;
        end else if (regAddr == `AOA_ADDR_Q_RANGE) begin
            regReadData <= qRange_reg;
        end else begin
            regReadData <= 16'h0000;
        end
    end

    // =============================================================
    // range selection: pin acts on both channels outside extended control
    wire [14:0] pinRange = fsrPinHigh ? `AOA_RANGE_HIGH : `AOA_RANGE_MID;

    always @(posedge clock) begin
        if (srst) begin
            iRangeCode <= `AOA_RANGE_MID;
            qRangeCode <= `AOA_RANGE_MID;
        end else if (ecmOn) begin
            iRangeCode <= iRange_reg[`AOA_RANGE_MSB:0];
            qRangeCode <= qRange_reg[`AOA_RANGE_MSB:0];
        end else begin
            iRangeCode <= pinRange;
            qRangeCode <= pinRange;
        end
    end

endmodule

// ==== verification/aoa_output_stage_sva.sv ====
// checker for the converter output stage, bound to its ports
// assumes register port in the clock domain and mode pins that settle in a few clocks
`timescale 1ns/1ps
module aoa_output_stage_sva #(
    parameter CODE_WIDTH = 10
) (
    input logic                  clock,
    input logic                  srst,
    input logic                  sampleClk,
    input logic                  demuxMode,
    input logic                  extended_control_mode,
    input logic                  full_scale_select_pin,
    input logic                  regWriteEn,
    input logic [3:0]            regAddr,
    input logic [15:0]           regWriteData,
    input logic [15:0]           regReadData,
    input logic [CODE_WIDTH-1:0] primary_i_bus,
    input logic [CODE_WIDTH-1:0] primary_q_bus,
    input logic [CODE_WIDTH-1:0] delayed_i_bus,
    input logic [CODE_WIDTH-1:0] delayed_q_bus,
    input logic                  primaryIBusOe,
    input logic                  primaryQBusOe,
    input logic                  delayedIBusOe,
    input logic                  delayedQBusOe,
    input logic                  i_over_range_flag,
    input logic                  q_over_range_flag,
    input logic [14:0]           iRangeCode,
    input logic [14:0]           qRangeCode
);
    // ==========================================================
    // helpers
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);
    // flags follow the mode seen at the last load, so hold off after a demux change
    logic       demuxSeen;
    logic [5:0] calm;
    always_ff @(posedge clock) begin
        demuxSeen <= demuxMode;
        calm      <= (srst || demuxMode != demuxSeen) ? 6'h00 : calm + {5'h00, calm != 6'h3F};
    end
    sequence demuxSteady; $stable(demuxMode) [*6]; endsequence
    sequence pinSteady; (!extended_control_mode && $stable(full_scale_select_pin)) [*6]; endsequence
    sequence iWrite; extended_control_mode [*6] ##0 (regWriteEn && regAddr == 4'h3)
        ##1 !regWriteEn [*3]; endsequence
    sequence iWriteRead; (regWriteEn && regAddr == 4'h3)
        ##1 (!regWriteEn && regAddr == 4'h3) [*2]; endsequence
    // pin rise: sync, edge, two delay stages, then the bus register
    sequence riseSeen; $past(sampleClk, 5) && !$past(sampleClk, 6); endsequence

    // ==========================================================
    // assertions
    AST_DELAYED_OE: assert property (
        demuxSteady |-> delayedIBusOe == demuxMode && delayedQBusOe == demuxMode)
        else $error("delayed bus enable does not follow demux mode");
    AST_PRIMARY_OE: assert property (
        $past(!srst) |-> primaryIBusOe && primaryQBusOe)
        else $error("primary bus not driven after reset");
    AST_I_FLAG_SET: assert property (
        calm == 6'h3F && i_over_range_flag |-> primary_i_bus == '0 || primary_i_bus == '1
        || delayedIBusOe && (delayed_i_bus == '0 || delayed_i_bus == '1))
        else $error("I flag high without a clipped I word");
    AST_I_FLAG_CLEAR: assert property (
        calm == 6'h3F && primary_i_bus != '0 && primary_i_bus != '1
        && !(delayedIBusOe && (delayed_i_bus == '0 || delayed_i_bus == '1))
        |-> !i_over_range_flag)
        else $error("I flag high with no clipped word shown");
    AST_Q_FLAG_SET: assert property (
        calm == 6'h3F && q_over_range_flag |-> primary_q_bus == '0 || primary_q_bus == '1
        || delayedQBusOe && (delayed_q_bus == '0 || delayed_q_bus == '1))
        else $error("Q flag high without a clipped Q word");
    AST_Q_FLAG_CLEAR: assert property (
        calm == 6'h3F && primary_q_bus != '0 && primary_q_bus != '1
        && !(delayedQBusOe && (delayed_q_bus == '0 || delayed_q_bus == '1))
        |-> !q_over_range_flag)
        else $error("Q flag high with no clipped word shown");
    AST_RANGE_PIN: assert property (
        pinSteady |-> iRangeCode == (full_scale_select_pin ? 15'h7FFF : 15'h4000)
        && qRangeCode == iRangeCode)
        else $error("pin range select not applied to both channels");
    AST_RANGE_REG: assert property (
        iWrite |-> {1'b0, iRangeCode} == ($past(regWriteData, 3) & 16'h7FFF))
        else $error("I range register not applied in extended control");
    AST_READBACK: assert property (
        iWriteRead |-> regReadData == ($past(regWriteData, 2) & 16'h7FFF))
        else $error("I range register read back wrong");
    AST_OUTPUT_DELAY: assert property (
        $changed(primary_i_bus) || $changed(primary_q_bus) |-> riseSeen)
        else $error("output word not a fixed delay after a sampling rise");
    AST_UNMAPPED: assert property (
        (regAddr != 4'h3 && regAddr != 4'hB) [*2] |-> regReadData == 16'h0000)
        else $error("unmapped read not zero");
endmodule

bind aoa_output_stage aoa_output_stage_sva #(.CODE_WIDTH(CODE_WIDTH)) u_sva (.*);

// ==== verification/aoa_capture_model.sv ====
// far-side capture logic: rebuilds sample order from the I buses
// assumes buses are sampled in the system clock domain
`timescale 1ns/1ps
module aoa_capture_model (
    input  wire       clock,
    input  wire [9:0] primaryBus,
    input  wire [9:0] delayedBus,
    input  wire       delayedOe,
    output reg  [9:0] olderWord,
    output reg  [9:0] newerWord
);
    // floating delayed bus is never used, the previous primary word stands in
    always @(posedge clock) begin
        olderWord <= delayedOe ? delayedBus : newerWord;
        newerWord <= primaryBus;
    end
endmodule

// ==== verification/aoa_testbench.sv ====
// self-checking bench: stream alignment in all four modes, clipping, flags, range select
// assumes 2FF input sync, two-clock output load and alternate-rise demux load
`timescale 1ns/1ps
module testbench;
    logic        clock = 0, srst = 1, sampleClk = 0, regWriteEn = 0, armed = 0;
    logic        demuxMode = 0, bothEdgeMode = 0;
    logic        extended_control_mode = 0, full_scale_select_pin = 0;
    logic [11:0] iAnalog = '0, qAnalog = '0;
    logic [3:0]  regAddr = '0;
    logic [15:0] regWriteData = '0, w;
    wire  [15:0] regReadData;
    wire  [9:0]  primary_i_bus, primary_q_bus, delayed_i_bus, delayed_q_bus;
    wire         primaryIBusOe, primaryQBusOe, delayedIBusOe, delayedQBusOe;
    wire         i_over_range_flag, q_over_range_flag;
    wire  [14:0] iRangeCode, qRangeCode;
    wire  [9:0]  pairOld, pairNew;
    logic [1:0]  lastMode = '0;
    int          settle = 0;
    int          errors = 0, n_compared = 0, cycles = 0, k, m, a, b, c, d, v;
    int          iq[$], qq[$], fq[$];
    integer      seed = 32'hcb6a_941e;

    aoa_output_stage uut (.*);
    aoa_capture_model partner (.clock(clock), .primaryBus(primary_i_bus),
        .delayedBus(delayed_i_bus), .delayedOe(delayedIBusOe), .olderWord(pairOld),
        .newerWord(pairNew));

    always #5 clock = ~clock;
    // sampling clock free-running at eight system clocks per period, each edge 8 ns after a system clock rise
    initial #13 forever #40 sampleClk = ~sampleClk;

    // ==========================================================
    // helpers
    function automatic logic [9:0] cd(input int x);
        return x > 511 ? 10'h3FF : x < -512 ? 10'h000 : 10'(x + 512);
    endfunction
    function automatic logic ov(input int x);
        return x > 511 || x < -512;
    endfunction
    function automatic int sI(input int n);
        return bothEdgeMode ? qq[$-n] : iq[$-n];
    endfunction
    function automatic int sQ(input int n);
        return bothEdgeMode ? fq[$-n] : qq[$-n];
    endfunction
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic final_report;
        $display("compared %0d, mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic wr(input logic [3:0] ad, input logic [15:0] dt);
        @(negedge clock);
        regWriteEn = 1;
        regAddr = ad;
        regWriteData = dt;
        @(negedge clock);
        regWriteEn = 0;
    endtask
    task automatic rd(input logic [3:0] ad, input logic [15:0] ex);
        @(negedge clock);
        regAddr = ad;
        repeat (2) @(negedge clock);
        check(regReadData, ex);
    endtask
    task automatic rng(input logic [14:0] ei, input logic [14:0] eq);
        repeat (8) @(negedge clock);
        check(iRangeCode, ei);
        check(qRangeCode, eq);
    endtask
    task automatic run(input logic dm, input logic be);
        @(negedge clock);
        demuxMode = dm;
        bothEdgeMode = be;
        armed = 1;
        repeat (70) @(posedge sampleClk);
    endtask

    // ==========================================================
    // stream: analog words change mid-way between edges, each noted for its edge
    always @(sampleClk) begin
        repeat (3) @(negedge clock);
        v = $random(seed) % 640;
        iAnalog <= v[11:0];
        if (!sampleClk) iq.push_back(v);
        v = $random(seed) % 640;
        qAnalog <= v[11:0];
        if (!sampleClk) qq.push_back(v);
        else fq.push_back(v);
    end
    // outputs seen at a rise come from the load of the previous rise, or in demux mode on alternate rises the one before
    // after a mode change the pipelines still hold old-mode words for 36 rises
    always @(posedge sampleClk) begin
        settle = ({demuxMode, bothEdgeMode} != lastMode) ? 0 : settle + 1;
        lastMode = {demuxMode, bothEdgeMode};
        if (armed && settle > 40 && iq.size() > 42 && fq.size() > 42) begin
            k = demuxMode && !(primary_i_bus === cd(sI(35)) && primary_q_bus === cd(sQ(35))
                && delayed_i_bus === cd(sI(36)) && delayed_q_bus === cd(sQ(36)));
            a = sI(35 + k);
            b = sQ(35 + k);
            c = sI(36 + k);
            d = sQ(36 + k);
            check(primary_i_bus, cd(a));
            check(primary_q_bus, cd(b));
            check(primaryIBusOe & primaryQBusOe, 16'h0001);
            check({delayedIBusOe, delayedQBusOe}, {2{demuxMode}});
            if (demuxMode) begin
                check(delayed_i_bus, cd(c));
                check(delayed_q_bus, cd(d));
                check(pairOld, cd(c));
                check(pairNew, cd(a));
            end
            check(i_over_range_flag, ov(a) | (demuxMode & ov(c)));
            check(q_over_range_flag, ov(b) | (demuxMode & ov(d)));
            void'(iq.pop_front());
            void'(qq.pop_front());
            void'(fq.pop_front());
        end
    end

    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            final_report;
        end
    end

    // ==========================================================
    // main sequence
    initial begin
        repeat (20) @(negedge clock);
        srst = 0;
        rd(4'h3, 16'h4000);
        rd(4'hB, 16'h4000);
        rng(15'h4000, 15'h4000);
        full_scale_select_pin = 1;
        rng(15'h7FFF, 15'h7FFF);
        w = $random(seed);
        wr(4'h3, w);
        rd(4'h3, w & 16'h7FFF);
        wr(4'hB, 16'hFFFF);
        rd(4'hB, 16'h7FFF);
        wr(4'h5, w);
        rd(4'h5, 16'h0000);
        extended_control_mode = 1;
        rng(w[14:0], 15'h7FFF);
        wr(4'h3, 16'h0001);
        rng(15'h0001, 15'h7FFF);
        for (m = 0; m < 4; m++) run(m[0], m[1]);
        final_report;
    end
endmodule
